// File: hdl/sdma_top.sv
// spi dma control: apb registers, sram byte mover, slave-select pulsing, watermark and time-out flag
// assumes a one-cycle sram read latency and a peer in clock-idle-low, sample-on-rising mode
// Summary of operation
// R01: receive-increment set advances the receive pointer after every received byte.
// R02: receive-increment clear writes every received byte to the same location.
// R03: duplex 10 full, 01 transmit only, 00 receive only, master or slave.
// R04: transmit-increment set steps the source address up, else it stays fixed.
// R05: slave with delay interrupt: flag when the gap between bytes exceeds the delay.
// R06: slave with delay interrupt still raises watermark interrupts.
// R07: delay interrupt clear gives no time-out flags; software programs delay 0000.
// R08: master, delay interrupt clear: add delay-field idle time between bytes.
// R09: master, delay interrupt set: minimum gap 8, 9 or 15 cycles by rate.
// R10: software keeps select control at 00 when master uses delay interrupt.
// R11: software sets delay 1111 and fast clock when master uses delay interrupt.
// R12: master: setting enable starts moving bytes at once.
// R13: slave: setting enable only prepares; bytes move when the master clocks.
// R14: software changes no configuration while enabled except the watermark.
// R15: clearing enable mid-transfer finishes the current byte, then goes idle.
// R16: after abort no pointer, counter or sram update.
// R17: select control 11/01/10 pulses select for 4/2/1 bytes, forces delay interrupt low.
// R18: select control 00 leaves select uncontrolled, delay interrupt writable.
// R19: hardware clears enable on completion or abort; enable reads session state.
// R20: delay interrupt flags once the delay passes after the last completed byte.
// R21: delay code: 1,2..128 doubling, then 128 steps to 896, 1024, 2048.
// R22: the byte counter decrements per byte and ends the session at zero.
// R23: flag at the watermark remaining count and again at completion.
`include "sdma_regs.svh"

module sdma_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             memRead,
  output logic             memWrite,
  output logic      [11:0] memAddr,
  output logic      [7:0]  memWdata,
  input  wire logic [7:0]  memRdata,
  input  wire logic        portClockIn,
  output logic             portClockOut,
  output logic             portClockOe,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOutOe,
  input  wire logic        portSlaveSelect_n,
  output logic             autoSlaveSelectOut_n,
  output logic             autoSlaveSelectOe,
  output logic             portInterruptFlag
);

  // ----------------------------------------------------------------
  // decode and lookup functions
  // ----------------------------------------------------------------
  function automatic sdma_pkg::sdma_sel_t sdma_decode(input logic [15:0] a);
    sdma_pkg::sdma_sel_t r;
    r = sdma_pkg::SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[15:2])
        `SDMA_IDX_CTRL1:   r = sdma_pkg::SEL_CTRL1;
        `SDMA_IDX_CTRL2:   r = sdma_pkg::SEL_CTRL2;
        `SDMA_IDX_COUNT:   r = sdma_pkg::SEL_COUNT;
        `SDMA_IDX_TXPTR:   r = sdma_pkg::SEL_TXPTR;
        `SDMA_IDX_RXPTR:   r = sdma_pkg::SEL_RXPTR;
        `SDMA_IDX_STATUS:  r = sdma_pkg::SEL_STATUS;
        `SDMA_IDX_PORTCFG: r = sdma_pkg::SEL_PORTCFG;
        default:           r = sdma_pkg::SEL_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [11:0] sdma_delay(input logic [3:0] c);
    logic [11:0] d;
    d = `SDMA_DLY_2048;
    if (c < 4'h8) begin
      d = 12'h001 << c;
    end else if (c < 4'hE) begin
      d = ({8'h00, c} - 12'h006) << `SDMA_DLY_STEP;
    end else if (c == 4'hE) begin
      d = `SDMA_DLY_1024;
    end
    return d; // R21
  endfunction

  function automatic logic [10:0] sdma_level(input logic [3:0] c);
    logic [10:0] l;
    l = ({7'h00, c} - 11'h006) << `SDMA_WM_STEP;
    if (c == 4'h0) begin
      l = 11'h000;
    end else if (c < 4'h7) begin
      l = 11'h001 << (c - 4'h1);
    end else if (c == 4'h7) begin
      l = `SDMA_WM_67;
    end
    return l;
  endfunction

  // ----------------------------------------------------------------
  // state and derived terms
  // ----------------------------------------------------------------
  sdma_pkg::sdma_state_t st;
  sdma_pkg::sdma_state_t next_st;
  sdma_pkg::sdma_sel_t   sel;
  logic                  shDone;
  logic                  shMid;
  logic [7:0]            shRx;
  logic                  needTx;
  logic                  needRx;
  logic [11:0]           curDelay;
  logic [11:0]           minGap;
  logic [11:0]           baseGap;
  logic [11:0]           gapLoad;
  logic [7:0]            halfPeriod;
  logic [2:0]            groupSize;
  logic                  wrTake;
  logic                  setFlag;
  logic                  clrFlag;

  assign sel = sdma_decode(paddr);
  assign wrTake = psel & penable & st.pready & pwrite;
  assign needTx = st.duplex != `SDMA_DUP_RXONLY; // R03
  assign needRx = st.duplex != `SDMA_DUP_TXONLY; // R03
  assign curDelay = sdma_delay(st.delay_cycle_field);

  always_comb begin
    case (st.rate)
      `SDMA_RATE_FAST: begin
        minGap = `SDMA_MINGAP_FAST;
        baseGap = `SDMA_BASEGAP_FAST;
        halfPeriod = `SDMA_HALF_FAST;
      end
      `SDMA_RATE_MID: begin
        minGap = `SDMA_MINGAP_MID;
        baseGap = `SDMA_BASEGAP_MID;
        halfPeriod = `SDMA_HALF_MID;
      end
      default: begin
        minGap = `SDMA_MINGAP_SLOW;
        baseGap = `SDMA_BASEGAP_SLOW;
        halfPeriod = `SDMA_HALF_SLOW;
      end
    endcase
    case (st.select_control_field)
      `SDMA_SS_FOUR: groupSize = 3'h4;
      `SDMA_SS_TWO:  groupSize = 3'h2;
      default:       groupSize = 3'h1;
    endcase
    if (!st.master) begin
      gapLoad = 12'h000;
    end else if (st.delay_interrupt_enable) begin
      gapLoad = minGap; // R09
    end else begin
      gapLoad = baseGap + curDelay; // R08
    end
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    setFlag = 1'b0;
    clrFlag = 1'b0;
    next_st.sync1 = {portClockIn, serialDataIn, portSlaveSelect_n};
    next_st.sync2 = st.sync1;
    next_st.shStart = 1'b0;
    next_st.memRead = 1'b0;
    next_st.memWrite = 1'b0;
    next_st.ssOe = st.master & (st.select_control_field != `SDMA_SS_OFF);
    next_st.sdoOe = st.master | ~st.sync2[0];
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = sel == sdma_pkg::SEL_NONE;
      case (sel)
        sdma_pkg::SEL_CTRL1:   next_st.prdata = {24'h0, st.select_control_field, st.tx_increment_enable, st.rx_increment_enable, st.duplex,
                                                 st.delay_interrupt_enable, st.enable}; // R19
        sdma_pkg::SEL_CTRL2:   next_st.prdata = {24'h0, st.delay_cycle_field, st.wmark};
        sdma_pkg::SEL_COUNT:   next_st.prdata = {22'h0, st.count};
        sdma_pkg::SEL_TXPTR:   next_st.prdata = {20'h0, st.txPtr};
        sdma_pkg::SEL_RXPTR:   next_st.prdata = {20'h0, st.rxPtr};
        sdma_pkg::SEL_STATUS:  next_st.prdata = {30'h0, st.enable, st.flag};
        sdma_pkg::SEL_PORTCFG: next_st.prdata = {29'h0, st.rate, st.master};
        default:               next_st.prdata = 32'h0;
      endcase
    end
    if (wrTake) begin
      case (sel)
        sdma_pkg::SEL_CTRL1: begin
          if (!st.enable) begin
            next_st.select_control_field = pwdata[`SDMA_C1_SELECT_CONTROL_FIELD];
            next_st.tx_increment_enable = pwdata[`SDMA_C1_TX_INCREMENT_ENABLE];
            next_st.rx_increment_enable = pwdata[`SDMA_C1_RX_INCREMENT_ENABLE];
            next_st.duplex = pwdata[`SDMA_C1_DUP];
            next_st.delay_interrupt_enable = (pwdata[`SDMA_C1_SELECT_CONTROL_FIELD] == `SDMA_SS_OFF) & pwdata[`SDMA_C1_DLYINT]; // R17 R18
            if (pwdata[`SDMA_C1_EN]) begin
              next_st.enable = 1'b1;
              next_st.wmDone = 1'b0;
              next_st.abort = 1'b0;
            end
          end else if (!pwdata[`SDMA_C1_EN]) begin
            next_st.abort = 1'b1; // R15
          end
        end
        sdma_pkg::SEL_CTRL2: begin
          next_st.wmark = pwdata[`SDMA_C2_WMARK];
          if (!st.enable) begin
            next_st.delay_cycle_field = pwdata[`SDMA_C2_DELAY_CYCLE_FIELD]; // R14
          end
        end
        sdma_pkg::SEL_COUNT:   if (!st.enable) next_st.count = pwdata[9:0];
        sdma_pkg::SEL_TXPTR:   if (!st.enable) next_st.txPtr = pwdata[11:0];
        sdma_pkg::SEL_RXPTR:   if (!st.enable) next_st.rxPtr = pwdata[11:0];
        sdma_pkg::SEL_STATUS:  clrFlag = pwdata[`SDMA_ST_FLAG];
        sdma_pkg::SEL_PORTCFG: begin
          if (!st.enable) begin
            next_st.master = pwdata[`SDMA_PC_MASTER];
            next_st.rate = pwdata[`SDMA_PC_RATE];
          end
        end
        default: ;
      endcase
    end
    case (st.fsm)
      sdma_pkg::FSM_IDLE: begin
        next_st.grp = 3'h0;
        if (st.enable) begin
          next_st.fsm = sdma_pkg::FSM_FETCH; // R12 R13
          next_st.memRead = needTx;
          next_st.memAddr = st.txPtr;
        end
      end
      sdma_pkg::FSM_FETCH: next_st.fsm = sdma_pkg::FSM_LOAD;
      sdma_pkg::FSM_LOAD: begin
        next_st.txByte = needTx ? memRdata : `SDMA_TX_FILL;
        next_st.shStart = 1'b1;
        next_st.fsm = sdma_pkg::FSM_SHIFT;
        if (st.master && st.select_control_field != `SDMA_SS_OFF) begin
          next_st.ssOut_n = 1'b0; // R17
        end
      end
      sdma_pkg::FSM_SHIFT: begin
        if (shDone && st.abort) begin
          next_st.enable = 1'b0; // R15 R16 R19
          next_st.abort = 1'b0;
          next_st.ssOut_n = 1'b1;
          next_st.fsm = sdma_pkg::FSM_IDLE;
        end else if (shDone) begin
          if (needRx) begin
            next_st.memWrite = 1'b1;
            next_st.memAddr = st.rxPtr;
            next_st.memWdata = shRx;
            if (st.rx_increment_enable) next_st.rxPtr = st.rxPtr + 12'h001; // R01 R02
          end
          if (needTx && st.tx_increment_enable) next_st.txPtr = st.txPtr + 12'h001; // R04
          next_st.grp = st.grp + 3'h1;
          if (st.grp + 3'h1 == groupSize) begin
            next_st.ssOut_n = 1'b1; // R17
            next_st.grp = 3'h0;
          end
          if (st.count == 10'h000) begin
            next_st.enable = 1'b0; // R19 R22
            next_st.ssOut_n = 1'b1;
            setFlag = 1'b1; // R23
            next_st.fsm = sdma_pkg::FSM_IDLE;
          end else begin
            next_st.count = st.count - 10'h001; // R22
            next_st.gap = gapLoad;
            next_st.fsm = sdma_pkg::FSM_GAP;
          end
        end else if (st.abort && !st.master && !shMid) begin
          next_st.enable = 1'b0; // R15
          next_st.abort = 1'b0;
          next_st.fsm = sdma_pkg::FSM_IDLE;
        end
      end
      sdma_pkg::FSM_GAP: begin
        if (st.abort) begin
          next_st.enable = 1'b0; // R16
          next_st.abort = 1'b0;
          next_st.ssOut_n = 1'b1;
          next_st.fsm = sdma_pkg::FSM_IDLE;
        end else if (st.gap == 12'h000) begin
          next_st.fsm = sdma_pkg::FSM_FETCH;
          next_st.memRead = needTx;
          next_st.memAddr = st.txPtr;
        end else begin
          next_st.gap = st.gap - 12'h001; // R08 R09
        end
      end
      default: next_st.fsm = sdma_pkg::FSM_IDLE;
    endcase
    if (st.enable && st.delay_interrupt_enable) begin
      if (shDone) begin
        next_st.tmo = 12'h000;
        next_st.tmoArmed = 1'b1;
      end else if (st.tmoArmed && st.tmo == curDelay) begin
        setFlag = 1'b1; // R05 R20
        next_st.tmoArmed = 1'b0;
      end else if (st.tmoArmed) begin
        next_st.tmo = st.tmo + 12'h001;
      end
    end else begin
      next_st.tmoArmed = 1'b0; // R07
    end
    if (st.enable && !st.wmDone && st.wmark != 4'h0 && {1'b0, st.count} + 11'h001 <= sdma_level(st.wmark)) begin
      setFlag = 1'b1; // R06 R23
      next_st.wmDone = 1'b1;
    end
    next_st.flag = (st.flag & ~clrFlag) | setFlag;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.ssOut_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  sdma_shift u_shift (
    .clk        (clk),
    .reset      (reset),
    .master     (st.master),
    .halfPeriod (halfPeriod),
    .start      (st.shStart),
    .txByte     (st.txByte),
    .sckIn      (st.sync2[2]),
    .sdiIn      (st.sync2[1]),
    .ssIn_n     (st.sync2[0]),
    .sckOut     (portClockOut),
    .sdo        (serialDataOut),
    .done       (shDone),
    .midByte    (shMid),
    .rxByte     (shRx)
  );

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign memRead = st.memRead;
  assign memWrite = st.memWrite;
  assign memAddr = st.memAddr;
  assign memWdata = st.memWdata;
  assign portClockOe = st.master;
  assign serialDataOutOe = st.sdoOe;
  assign autoSlaveSelectOut_n = st.ssOut_n;
  assign autoSlaveSelectOe = st.ssOe;
  assign portInterruptFlag = st.flag;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_done_flag: assert property (st.fsm == sdma_pkg::FSM_SHIFT && shDone && !st.abort && st.count == 10'h000 // R22
    |=> st.flag && !st.enable && st.fsm == sdma_pkg::FSM_IDLE) else $error("completion missed flag");
  a_abort_quiet: assert property (st.fsm == sdma_pkg::FSM_SHIFT && shDone && st.abort // R16
    |=> !st.memWrite && !st.enable && $stable(st.txPtr) && $stable(st.rxPtr) && $stable(st.count))
    else $error("abort still updated state");
  a_rx_fixed: assert property (st.enable && !st.rx_increment_enable |=> $stable(st.rxPtr)) else $error("rx pointer moved"); // R02
  a_tx_fixed: assert property (st.enable && !st.tx_increment_enable |=> $stable(st.txPtr)) else $error("tx pointer moved"); // R04
  a_rx_step: assert property (st.fsm == sdma_pkg::FSM_SHIFT && shDone && !st.abort && st.rx_increment_enable && needRx // R01
    |=> st.memWrite && st.rxPtr == $past(st.rxPtr) + 12'h001) else $error("rx pointer not stepped");
  a_select_control_field_dly: assert property (st.select_control_field != `SDMA_SS_OFF |-> !st.delay_interrupt_enable) else $error("delay int not forced"); // R17
  a_ss_idle: assert property (st.select_control_field == `SDMA_SS_OFF |-> st.ssOut_n) else $error("select driven while off"); // R18
  a_master_go: assert property ($rose(st.enable) && st.master |=> st.fsm == sdma_pkg::FSM_FETCH // R12
    ##1 st.fsm == sdma_pkg::FSM_LOAD ##1 st.fsm == sdma_pkg::FSM_SHIFT) else $error("master did not start");
  a_gap_min: assert property (st.master && st.delay_interrupt_enable && st.fsm == sdma_pkg::FSM_SHIFT && shDone && !st.abort // R09
    && st.count != 10'h000 |=> (st.fsm == sdma_pkg::FSM_GAP || !st.enable) [*8]) else $error("gap too short");
  a_tmo_flag: assert property (st.enable && st.delay_interrupt_enable && st.tmoArmed && !shDone && st.tmo == curDelay // R05
    |=> st.flag) else $error("time-out flag missing");
  a_apb_ready: assert property (psel && penable && !st.pready |=> st.pready) else $error("pready late");

  c_complete: cover property (st.fsm == sdma_pkg::FSM_SHIFT && shDone && st.count == 10'h000);
  c_abort: cover property (st.fsm == sdma_pkg::FSM_SHIFT && shDone && st.abort);
  c_timeout: cover property (st.tmoArmed && st.tmo == curDelay && st.enable && st.delay_interrupt_enable);
  c_watermark: cover property (!st.wmDone ##1 st.wmDone);

endmodule // sdma_top

// File: hdl/sdma_regs.svh
// register indices, field positions, codes and timing counts of the spi dma control block
// assumes byte address = 4 * index on a 32-bit apb bus
`ifndef SDMA_REGS_SVH
`define SDMA_REGS_SVH

`define SDMA_IDX_CTRL1    14'h0F88
`define SDMA_IDX_CTRL2    14'h0F86
`define SDMA_IDX_COUNT    14'h0F90
`define SDMA_IDX_TXPTR    14'h0F91
`define SDMA_IDX_RXPTR    14'h0F92
`define SDMA_IDX_STATUS   14'h0F93
`define SDMA_IDX_PORTCFG  14'h0F94

`define SDMA_CTRL_RESET   8'h00
`define SDMA_C1_EN        0
`define SDMA_C1_DLYINT    1
`define SDMA_C1_DUP       3:2
`define SDMA_C1_RX_INCREMENT_ENABLE     4
`define SDMA_C1_TX_INCREMENT_ENABLE     5
`define SDMA_C1_SELECT_CONTROL_FIELD     7:6
`define SDMA_C2_WMARK     3:0
`define SDMA_C2_DELAY_CYCLE_FIELD    7:4
`define SDMA_PC_MASTER    0
`define SDMA_PC_RATE      2:1
`define SDMA_ST_FLAG      0

`define SDMA_DUP_FULL     2'h2
`define SDMA_DUP_TXONLY   2'h1
`define SDMA_DUP_RXONLY   2'h0
`define SDMA_SS_OFF       2'h0
`define SDMA_SS_FOUR      2'h3
`define SDMA_SS_TWO       2'h1
`define SDMA_SS_ONE       2'h2

`define SDMA_RATE_FAST    2'h0
`define SDMA_RATE_MID     2'h1
// master half periods; at least 2 so that the falling-edge sample sees settled input
`define SDMA_HALF_FAST    8'h02
`define SDMA_HALF_MID     8'h04
`define SDMA_HALF_SLOW    8'h10
`define SDMA_MINGAP_FAST  12'h008
`define SDMA_MINGAP_MID   12'h009
`define SDMA_MINGAP_SLOW  12'h00F
`define SDMA_BASEGAP_FAST 12'h007
`define SDMA_BASEGAP_MID  12'h008
`define SDMA_BASEGAP_SLOW 12'h00E
`define SDMA_DLY_1024     12'h400
`define SDMA_DLY_2048     12'h800
`define SDMA_DLY_STEP     7
`define SDMA_WM_67        11'h043
`define SDMA_WM_STEP      6
`define SDMA_TX_FILL      8'hFF

`endif

// File: hdl/sdma_pkg.sv
// types of the spi dma control block
// assumes sdma_regs.svh for all numeric constants
package sdma_pkg;

  typedef enum logic [2:0] {FSM_IDLE, FSM_FETCH, FSM_LOAD, FSM_SHIFT, FSM_GAP} sdma_fsm_t;

  typedef enum logic [2:0] {SEL_CTRL1, SEL_CTRL2, SEL_COUNT, SEL_TXPTR, SEL_RXPTR,
                            SEL_STATUS, SEL_PORTCFG, SEL_NONE} sdma_sel_t;

  typedef struct packed {
    logic       busy;
    logic       sck;
    logic       sdo;
    logic       done;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bits;
    logic [7:0] timer;
    logic       sckPrev;
  } sdma_shift_t;

  typedef struct packed {
    logic [1:0]  select_control_field;
    logic        tx_increment_enable;
    logic        rx_increment_enable;
    logic [1:0]  duplex;
    logic        delay_interrupt_enable;
    logic        enable;
    logic [3:0]  delay_cycle_field;
    logic [3:0]  wmark;
    logic        master;
    logic [1:0]  rate;
    logic [9:0]  count;
    logic [11:0] txPtr;
    logic [11:0] rxPtr;
    logic        flag;
    logic        wmDone;
    logic        abort;
    sdma_fsm_t   fsm;
    logic [11:0] gap;
    logic [11:0] tmo;
    logic        tmoArmed;
    logic [2:0]  grp;
    logic        ssOut_n;
    logic        ssOe;
    logic        sdoOe;
    logic        memRead;
    logic        memWrite;
    logic [11:0] memAddr;
    logic [7:0]  memWdata;
    logic [7:0]  txByte;
    logic        shStart;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sdma_state_t;

endpackage

// File: hdl/sdma_shift.sv
// one-byte serial shifter, clock idle low, data changes on the falling edge, peer samples on the rising edge
// assumes sckIn, sdiIn, ssIn_n are already synchronised to clk
module sdma_shift (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       master,
  input  wire logic [7:0] halfPeriod,
  input  wire logic       start,
  input  wire logic [7:0] txByte,
  input  wire logic       sckIn,
  input  wire logic       sdiIn,
  input  wire logic       ssIn_n,
  output logic            sckOut,
  output logic            sdo,
  output logic            done,
  output logic            midByte,
  output logic [7:0]      rxByte
);

  sdma_pkg::sdma_shift_t s;
  sdma_pkg::sdma_shift_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.sckPrev = sckIn;
    if (start) begin
      next_s.busy = 1'b1;
      next_s.tx = txByte;
      next_s.sdo = txByte[7];
      next_s.bits = 3'h0;
      next_s.sck = 1'b0;
      next_s.timer = halfPeriod;
    end else if (s.busy && master) begin
      if (s.timer == 8'h01) begin
        next_s.timer = halfPeriod;
        next_s.sck = ~s.sck;
        // master takes the input bit at the falling edge: the two-flop input path lags two cycles
        if (s.sck) begin
          next_s.rx = {s.rx[6:0], sdiIn};
        end
        if (s.sck && s.bits == 3'h7) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end else if (s.sck) begin
          next_s.bits = s.bits + 3'h1;
          next_s.tx = {s.tx[6:0], 1'b0};
          next_s.sdo = s.tx[6];
        end
      end else begin
        next_s.timer = s.timer - 8'h01;
      end
    end else if (s.busy && !ssIn_n) begin
      // slave: edges come from the outside master
      if (sckIn && !s.sckPrev) begin
        next_s.rx = {s.rx[6:0], sdiIn};
        if (s.bits == 3'h7) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end else begin
          next_s.bits = s.bits + 3'h1;
        end
      end else if (!sckIn && s.sckPrev && s.bits != 3'h0) begin
        next_s.tx = {s.tx[6:0], 1'b0};
        next_s.sdo = s.tx[6];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sckOut = s.sck;
  assign sdo = s.sdo;
  assign done = s.done;
  assign midByte = s.busy & (s.bits != 3'h0);
  assign rxByte = s.rx;

endmodule // sdma_shift

// File: sim/sdma_peer.sv
// spi slave peer: clock idle low, sample on rising edge, msb first
// assumes it is always selected and driven by the block's serial clock
module sdma_peer (
  input  wire logic sck,
  input  wire logic sdo,
  output logic      sdi,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // byte k of the stream is A5 xor k
  // ----------------------------------------
  int unsigned cnt = 0;
  logic [7:0]  cur;
  assign cur = 8'hA5 ^ 8'(cnt / 8);
  initial sdi = 1'b1;
  always @(posedge sck) begin
    got <= {got[6:0], sdo};
    cnt <= cnt + 1;
  end
  always @(negedge sck) begin
    sdi <= cur[3'd7 - 3'(cnt % 8)];
  end
endmodule // sdma_peer

// File: sim/testbench.sv
// self-checking bench: apb master, sram model and spi peer
// assumes master role except in t_slave; the peer stays selected
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, memRead, memWrite, portClockOut, portClockOe, serialDataIn;
  logic serialDataOut, serialDataOutOe, autoSlaveSelectOut_n, autoSlaveSelectOe, portInterruptFlag;
  logic portClockIn = 1'b0, portSlaveSelect_n = 1'b1;
  logic [11:0] memAddr, wa;
  logic [7:0] memWdata, memRdata = 8'h00, wd, got;
  int error_cnt = 0, checks_done = 0, wn = 0, w0;
  always #12.5 clk = ~clk;
  sdma_top dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .memRead, .memWrite, .memAddr, .memWdata, .memRdata, .portClockIn, .portClockOut, .portClockOe,
    .serialDataIn, .serialDataOut, .serialDataOutOe, .portSlaveSelect_n, .autoSlaveSelectOut_n,
    .autoSlaveSelectOe, .portInterruptFlag);
  sdma_peer peer_u (.sck(portClockOut), .sdo(serialDataOut), .sdi(serialDataIn), .got(got));
  // ----------------------------------------
  // sram: one-cycle read, writes logged
  // ----------------------------------------
  always @(posedge clk) begin
    if (memRead)
      memRdata <= memAddr[7:0] ^ 8'h3C;
    if (memWrite) begin
      wa <= memAddr;
      wd <= memWdata;
      wn <= wn + 1;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task give_verdict;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++i < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  task poll;
    int i;
    for (i = 0; i < 300; i++) begin
      apb(1'b0, 16'h3E4C, 32'h0);
      if (rd[1] === 1'b0)
        break;
    end
    chk(32'(i < 300), 32'h1);
    if (i >= 300)
      give_verdict;
  endtask
  task run(input logic [7:0] c1, input logic [9:0] n);
    apb(1'b1, 16'h3E4C, 32'h1);
    apb(1'b1, 16'h3E50, 32'h3);
    apb(1'b1, 16'h3E44, 32'h100);
    apb(1'b1, 16'h3E48, 32'h200);
    apb(1'b1, 16'h3E40, 32'(n));
    w0 = wn;
    apb(1'b1, 16'h3E20, 32'(c1));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    apb(1'b0, 16'h3E20, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h3E00, 32'h0);
    chk(32'(perr), 32'h1);
    $display("regs done");
  endtask
  task t_full;
    run(8'h39, 10'h002);
    poll;
    chk(wn - w0, 3);
    chk(32'(wa), 32'h202);
    chk(32'(wd), 32'hA7);
    chk(32'(got), 32'h3E);
    apb(1'b0, 16'h3E40, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h3E4C, 32'h0);
    chk(32'(rd[0]), 32'h1);
    chk(32'(portInterruptFlag), 32'h1);
    $display("full duplex done");
  endtask
  task t_rx;
    run(8'h01, 10'h001);
    poll;
    chk(wn - w0, 2);
    chk(32'(wa), 32'h200);
    chk(32'(wd), 32'hA1);
    chk(32'(got), 32'hFF);
    $display("receive only done");
  endtask
  task t_tx;
    run(8'h05, 10'h001);
    poll;
    chk(wn - w0, 0);
    chk(32'(got), 32'h3C);
    $display("transmit only done");
  endtask
  task t_abort;
    int i;
    run(8'h39, 10'h009);
    for (i = 0; i < 600 && wn == w0; i++)
      @(posedge clk);
    chk(32'(i < 600), 32'h1);
    if (i >= 600)
      give_verdict;
    apb(1'b1, 16'h3E20, 32'h38);
    poll;
    chk(32'(wn - w0 <= 2), 32'h1);
    apb(1'b0, 16'h3E40, 32'h0);
    chk(32'(rd != 0), 32'h1);
    $display("abort done");
  endtask
  task t_dly;
    apb(1'b1, 16'h3E18, 32'hF0);
    run(8'h3B, 10'h001);
    poll;
    chk(wn - w0, 2);
    chk(32'(wd), 32'hAD);
    chk(32'(got), 32'h3D);
    apb(1'b0, 16'h3E20, 32'h0);
    chk(rd, 32'h3A);
    apb(1'b1, 16'h3E20, 32'hC2);
    apb(1'b0, 16'h3E20, 32'h0);
    chk(rd, 32'hC0);
    chk(32'({autoSlaveSelectOe, autoSlaveSelectOut_n, portClockOe, serialDataOutOe}), 32'hF);
    apb(1'b1, 16'h3E18, 32'h0);
    $display("delay interrupt done");
  endtask
  task t_slave;
    apb(1'b1, 16'h3E50, 32'h0);
    apb(1'b1, 16'h3E40, 32'h0);
    w0 = wn;
    apb(1'b1, 16'h3E20, 32'h1);
    repeat (100) @(posedge clk);
    apb(1'b0, 16'h3E4C, 32'h0);
    chk(32'(rd[1]), 32'h1);
    chk(wn - w0, 0);
    chk(32'({portClockOe, serialDataOutOe}), 32'h0);
    apb(1'b1, 16'h3E20, 32'h0);
    poll;
    $display("slave done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_full;
    t_rx;
    t_tx;
    t_dly;
    t_abort;
    t_slave;
    give_verdict;
  end
endmodule // testbench
